//--- src/isf_pkg.sv
package isf_pkg;

	// Status word bit positions
	localparam int unsigned ISF_BIT_TX_FULL = 0;
	localparam int unsigned ISF_BIT_RX_FULL = 1;
	localparam int unsigned ISF_BIT_READ_DIR = 2;
	localparam int unsigned ISF_BIT_BEGIN = 3;
	localparam int unsigned ISF_BIT_HALT = 4;
	localparam int unsigned ISF_BIT_DATA = 5;
	localparam int unsigned ISF_STAT_W = 6;

	// Value of every flag after reset
	localparam logic ISF_FLAG_RST = 1'b0;
	localparam logic [7:0] ISF_BYTE_RST = 8'h00;
	// Pin level assumed during reset: idle bus lines sit high
	localparam logic ISF_LINE_IDLE = 1'b1;

	// Bits in one bus byte, address byte included
	localparam int unsigned ISF_BYTE_BITS = 8;
	// Bits including the acknowledge slot
	localparam int unsigned ISF_FRAME_BITS = 9;

	// Default target address (arbitrary value)
	localparam logic [6:0] ISF_OWN_ADDR_DEF = 7'h2A;

	// Bit counter width
	localparam int unsigned ISF_CNT_W = 4;

	// Target byte-phase state machine
	typedef enum logic [1:0] {
		ISF_IDLE,
		ISF_ADDR,
		ISF_DATA,
		ISF_SKIP
	} isf_phase_t;

endpackage : isf_pkg

//--- src/isf_status_flags.sv
`timescale 1ns/1ps
// Operation
// - Target: address match clears, next byte sets data
// - Halt-seen flag high when stop seen last
// - Begin-seen flag high when start seen last
// - Both condition flags updated on every condition
// - Target: direction flag from address byte bit
// - Receive-full set when received byte stored
// - Receive-full cleared when software reads holding register
// - Transmit-full set when software writes transmit register
// - Transmit-full cleared when byte transmission completes

module isf_status_flags (
	// Clock, reset, enable
	input wire logic clock,
	input wire logic arst_n,
	input wire logic ce,
	// Bus pins (sampled)
	input wire logic scl_in,
	input wire logic sda_in,
	// Configuration
	input wire logic target_en,
	input wire logic [6:0] own_addr,
	// Software side
	input wire logic rx_read,
	input wire logic tx_write,
	input wire logic [7:0] tx_wdata,
	// Transmit engine side
	input wire logic tx_done,
	// Receive and transmit holding registers
	output logic [7:0] rx_holding_reg,
	output logic [7:0] tx_holding_reg,
	// Status word and single flags
	output logic [isf_pkg::ISF_STAT_W-1:0] bus_status_reg,
	output logic rx_full,
	output logic tx_full,
	output logic addr_hit
);
	import isf_pkg::*;

	logic scl_lvl; // Synchronised clock line
	logic scl_rise; // Clock rising edge
	logic sda_lvl; // Synchronised data line
	logic sda_rise; // Data rising edge
	logic sda_fall; // Data falling edge
	logic begin_ev; // Start or repeated start
	logic halt_ev; // Stop condition
	isf_phase_t phase_q; // Byte phase
	logic [ISF_CNT_W-1:0] cnt_q; // Bit count in frame
	logic [7:0] shift_q; // Incoming byte
	logic [7:0] byte_now; // Byte including the current bit
	logic byte_end; // Eighth bit sampled
	logic halt_q; // Stop seen last
	logic begin_q; // Start seen last
	logic data_q; // Last byte was data
	logic dir_q; // Read requested
	logic rx_full_q; // Receive holding full
	logic tx_full_q; // Transmit holding full
	logic hit_q; // Address matched this frame
	logic [7:0] rx_q; // Receive holding register
	logic [7:0] tx_q; // Transmit holding register

	// Own-address decode; the direction bit is left out
	function automatic logic addr_match(input logic [7:0] b, input logic [6:0] a);
		return b[7:1] == a;
	endfunction : addr_match

	// Pin synchronisers
	// Falling clock edge not needed: bits are taken on the rise
	isf_sync u_scl (
		.clock(clock),
		.arst_n(arst_n),
		.ce(ce),
		.pin(scl_in),
		.level(scl_lvl),
		.rise(scl_rise),
		.fall()
	);

	isf_sync u_sda (
		.clock(clock),
		.arst_n(arst_n),
		.ce(ce),
		.pin(sda_in),
		.level(sda_lvl),
		.rise(sda_rise),
		.fall(sda_fall)
	);

	// Conditions: data moves while clock is high
	assign begin_ev = sda_fall & scl_lvl;
	assign halt_ev = sda_rise & scl_lvl;
	assign byte_now = {shift_q[6:0], sda_lvl};
	assign byte_end = scl_rise && (cnt_q == ISF_CNT_W'(ISF_BYTE_BITS - 1));

	// Bit counter and shifter; only the counter restarts on any condition
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= '0;
			shift_q <= ISF_BYTE_RST;
		end else if (ce) begin
			// A condition always starts a fresh frame
			if (begin_ev || halt_ev) begin
				cnt_q <= '0;
			end else if (scl_rise) begin
				shift_q <= byte_now;
				// Acknowledge slot closes the frame
				if (cnt_q == ISF_CNT_W'(ISF_FRAME_BITS - 1)) begin
					cnt_q <= '0;
				end else begin
					cnt_q <= cnt_q + 1'b1;
				end
			end
		end
	end

	// Target byte-phase sequence
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			phase_q <= ISF_IDLE;
			hit_q <= ISF_FLAG_RST;
		end else if (ce) begin
			if (begin_ev) begin
				phase_q <= ISF_ADDR;
				hit_q <= 1'b0;
			end else if (halt_ev) begin
				phase_q <= ISF_IDLE;
				hit_q <= 1'b0;
			end else if (byte_end) begin
				case (phase_q)
					ISF_ADDR: begin
						// Foreign address: ignore until next condition
						if (target_en && addr_match(byte_now, own_addr)) begin
							phase_q <= ISF_DATA;
							hit_q <= 1'b1;
						end else begin
							phase_q <= ISF_SKIP;
						end
					end
					// Matched: every further byte is data
					ISF_DATA: phase_q <= ISF_DATA;
					// Foreign frame: wait for a condition
					ISF_SKIP: phase_q <= ISF_SKIP;
					// Byte with no start seen since reset or the last stop
					default: phase_q <= ISF_IDLE;
				endcase
			end
		end
	end

	// Condition flags; one is set, the other cleared
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			halt_q <= ISF_FLAG_RST;
			begin_q <= ISF_FLAG_RST;
		end else if (ce) begin
			if (begin_ev) begin
				begin_q <= 1'b1;
				halt_q <= 1'b0;
			end else if (halt_ev) begin
				halt_q <= 1'b1;
				begin_q <= 1'b0;
			end
		end
	end

	// Data/address and direction flags in target operation
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			data_q <= ISF_FLAG_RST;
			dir_q <= ISF_FLAG_RST;
		end else if (ce && byte_end && target_en) begin
			if (phase_q == ISF_ADDR && addr_match(byte_now, own_addr)) begin
				data_q <= 1'b0;
				dir_q <= byte_now[0];
			end else if (phase_q == ISF_DATA) begin
				// Read-direction bytes count as data too
				data_q <= 1'b1;
			end
		end
	end

	// Receive holding register and its full flag; set beats clear
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rx_q <= ISF_BYTE_RST;
			rx_full_q <= ISF_FLAG_RST;
		end else if (ce) begin
			// Only write-direction data lands in the holding register
			if (byte_end && phase_q == ISF_DATA && !dir_q) begin
				rx_q <= byte_now;
				rx_full_q <= 1'b1;
			end else if (rx_read) begin
				rx_full_q <= 1'b0;
			end
		end
	end

	// Transmit holding register and its full flag; set beats clear
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			tx_q <= ISF_BYTE_RST;
			tx_full_q <= ISF_FLAG_RST;
		end else if (ce) begin
			// A write in the cycle of completion keeps the flag set
			if (tx_write) begin
				tx_q <= tx_wdata;
				tx_full_q <= 1'b1;
			end else if (tx_done) begin
				tx_full_q <= 1'b0;
			end
		end
	end

	// Status word driven straight from flops
	assign bus_status_reg = {data_q, halt_q, begin_q, dir_q, rx_full_q, tx_full_q};
	assign rx_full = rx_full_q;
	assign tx_full = tx_full_q;
	assign addr_hit = hit_q;
	assign rx_holding_reg = rx_q;
	assign tx_holding_reg = tx_q;

endmodule : isf_status_flags

//--- src/isf_sync.sv
`timescale 1ns/1ps

// Two-flop synchroniser plus edge finder for one pin
module isf_sync (
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	input wire logic ce,
	// Pin side
	input wire logic pin,
	// Synchronised level and edges
	output logic level,
	output logic rise,
	output logic fall
);
	import isf_pkg::*;

	logic meta_q; // First stage, read only by the second
	logic sync_q; // Second stage
	logic prev_q; // Last settled level

	// Synchroniser chain; idle bus level is high
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			meta_q <= ISF_LINE_IDLE;
			sync_q <= ISF_LINE_IDLE;
			prev_q <= ISF_LINE_IDLE;
		end else if (ce) begin
			meta_q <= pin;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign level = sync_q;
	assign rise = sync_q & ~prev_q;
	assign fall = ~sync_q & prev_q;

endmodule : isf_sync

//--- verification/isf_bus_model.sv
`timescale 1ns/1ps
// Bus controller model; clock line stands high between frames
module isf_bus_model (
	// Bus lines
	output logic scl,
	output logic sda
);
	// Idle bus
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	// Start: data falls while clock high
	task automatic start();
		#120 sda = 1'b0;
		#120 scl = 1'b0;
	endtask : start
	// Byte MSB first, then a low acknowledge slot
	task automatic send(input logic [7:0] b);
		for (int i = 8; i >= 0; i--) begin
			#20 sda = (i > 0) ? b[i-1] : 1'b0;
			#60 scl = 1'b1;
			#80 scl = 1'b0;
		end
	endtask : send
	// Stop: data rises while clock high
	task automatic stop();
		#20 sda = 1'b0;
		#60 scl = 1'b1;
		#80 sda = 1'b1;
	endtask : stop
endmodule : isf_bus_model

//--- verification/isf_status_flags_chk.sv
`timescale 1ns/1ps
// Flag relations seen at the block ports
module isf_status_flags_chk (
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	input wire logic ce,
	// Bus lines
	input wire logic scl_in,
	input wire logic sda_in,
	// Software side
	input wire logic rx_read,
	input wire logic tx_write,
	input wire logic [7:0] tx_wdata,
	input wire logic tx_done,
	// Flag outputs
	input wire logic [7:0] rx_holding_reg,
	input wire logic [7:0] tx_holding_reg,
	input wire logic [isf_pkg::ISF_STAT_W-1:0] bus_status_reg,
	input wire logic rx_full,
	input wire logic tx_full,
	input wire logic addr_hit
);
	import isf_pkg::*;
	// Short view of the status word
	logic [ISF_STAT_W-1:0] s;
	assign s = bus_status_reg;
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	property p_rst; disable iff (1'b0) !arst_n |-> s == '0; endproperty
	a_rst: assert property (p_rst) else $error("flags not clear in reset");
	property p_tx_set; tx_write && ce |=> tx_full && tx_holding_reg == $past(tx_wdata); endproperty
	a_tx_set: assert property (p_tx_set) else $error("write not taken");
	property p_tx_clr; tx_done && !tx_write && ce |=> !tx_full; endproperty
	a_tx_clr: assert property (p_tx_clr) else $error("tx flag stuck");
	property p_rx_clr; rx_read && ce |=> !rx_full || $changed(rx_holding_reg); endproperty
	a_rx_clr: assert property (p_rx_clr) else $error("rx flag stuck");
	property p_rx_set; $rose(rx_full) |-> s[ISF_BIT_DATA] && !s[ISF_BIT_READ_DIR]; endproperty
	a_rx_set: assert property (p_rx_set) else $error("rx set off a data write");
	property p_halt; $rose(s[ISF_BIT_HALT]) |-> sda_in && scl_in && !s[ISF_BIT_BEGIN]; endproperty
	a_halt: assert property (p_halt) else $error("halt flag without stop");
	property p_begin; $rose(s[ISF_BIT_BEGIN]) |-> !sda_in && scl_in && !s[ISF_BIT_HALT]; endproperty
	a_begin: assert property (p_begin) else $error("begin flag without start");
	property p_dir; $changed(s[ISF_BIT_READ_DIR]) |-> !s[ISF_BIT_DATA]; endproperty
	a_dir: assert property (p_dir) else $error("direction moved off address");
	property p_data; $rose(s[ISF_BIT_DATA]) |-> addr_hit; endproperty
	a_data: assert property (p_data) else $error("data flag without match");
	// Main scenarios
	c_rx: cover property ($rose(rx_full));
	c_halt: cover property ($rose(s[ISF_BIT_HALT]));
	c_tx: cover property (tx_write && tx_done && ce);
endmodule : isf_status_flags_chk

bind isf_status_flags isf_status_flags_chk u_chk (.clock, .arst_n, .ce, .scl_in, .sda_in,
	.rx_read, .tx_write, .tx_wdata, .tx_done, .rx_holding_reg, .tx_holding_reg,
	.bus_status_reg, .rx_full, .tx_full, .addr_hit);

//--- verification/test_isf_status_flags.sv
`timescale 1ns/1ps
// Self-checking bench for the status flag block
module test_isf_status_flags;
	import isf_pkg::*;
	// Stimulus and outputs
	logic clock = 1'b0;
	logic arst_n = 1'b1;
	logic ce = 1'b1;
	logic target_en = 1'b1;
	logic rx_read = 1'b0;
	logic tx_write = 1'b0;
	logic tx_done = 1'b0;
	logic [7:0] tx_wdata = 8'h00;
	logic scl_in;
	logic sda_in;
	logic [7:0] rx_holding_reg;
	logic [7:0] tx_holding_reg;
	logic [ISF_STAT_W-1:0] bus_status_reg;
	logic rx_full;
	logic tx_full;
	int errors = 0;
	int n_tests = 0;
	// Rows: address byte, data byte, expected rx byte, expected status
	logic [29:0] rows [3] = '{{8'h2B, 8'h11, 8'h00, 6'h08},
		{8'h54, 8'hA5, 8'hA5, 6'h2A}, {8'h55, 8'h3C, 8'hA5, 6'h2C}};
	isf_bus_model bus (.scl(scl_in), .sda(sda_in));
	isf_status_flags dut (.clock, .arst_n, .ce, .scl_in, .sda_in, .target_en,
		.own_addr(ISF_OWN_ADDR_DEF), .rx_read, .tx_write, .tx_wdata, .tx_done,
		.rx_holding_reg, .tx_holding_reg, .bus_status_reg, .rx_full, .tx_full, .addr_hit());
	// Compare and count
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	// Verdict
	task automatic wrap_up();
		if (errors == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : wrap_up
	always #10 clock = ~clock;
	// Main sequence
	initial begin
		#1 arst_n = 1'b0;
		repeat (3) @(posedge clock);
		#1 arst_n = 1'b1;
		check({2'h0, bus_status_reg}, 8'h00);
		foreach (rows[i]) begin
			bus.start();
			bus.send(rows[i][29:22]);
			bus.send(rows[i][21:14]);
			repeat (4) @(posedge clock);
			#1 check({2'h0, bus_status_reg}, {2'h0, rows[i][5:0]});
			check(rx_holding_reg, rows[i][13:6]);
			check({7'h0, rx_full}, {7'h0, rows[i][1]});
			rx_read = 1'b1;
			@(posedge clock);
			#1 rx_read = 1'b0;
			bus.stop();
			repeat (8) @(posedge clock);
			#1;
			check({2'h0, bus_status_reg}, {2'h0, rows[i][5:0] & 6'h35 | 6'h10});
		end
		// Write and completion in one cycle: the write wins
		tx_wdata = 8'hC3;
		tx_write = 1'b1;
		tx_done = 1'b1;
		@(posedge clock);
		#1 tx_write = 1'b0;
		check(tx_holding_reg, 8'hC3);
		check({7'h0, tx_full}, 8'h01);
		@(posedge clock);
		#1 tx_done = 1'b0;
		check({7'h0, tx_full}, 8'h00);
		// Enable low: a write must not land
		ce = 1'b0;
		tx_wdata = 8'h5A;
		tx_write = 1'b1;
		@(posedge clock);
		#1 tx_write = 1'b0;
		ce = 1'b1;
		check(tx_holding_reg, 8'hC3);
		check({7'h0, tx_full}, 8'h00);
		// Target operation off: only the condition flags may move
		target_en = 1'b0;
		bus.start();
		bus.send(8'h54);
		bus.send(8'h77);
		repeat (4) @(posedge clock);
		#1 check({2'h0, bus_status_reg}, 8'h2C);
		check(rx_holding_reg, 8'hA5);
		bus.stop();
		repeat (8) @(posedge clock);
		#1 check({2'h0, bus_status_reg}, 8'h34);
		// Reset in mid-run clears every flag and register
		arst_n = 1'b0;
		@(posedge clock);
		#1 check({2'h0, bus_status_reg}, 8'h00);
		check(tx_holding_reg, ISF_BYTE_RST);
		check(rx_holding_reg, ISF_BYTE_RST);
		arst_n = 1'b1;
		repeat (2) @(posedge clock);
		#1 check({2'h0, bus_status_reg}, 8'h00);
		wrap_up();
	end
endmodule : test_isf_status_flags
